// ==== logic/secl_pkg.sv ====
// Purpose: Shared constants and types for the serial EEPROM configuration loader.
// Assumes: A two-wire serial EEPROM answering at a fixed device address.
// Notes: Every address, marker, mask and timing value the loader uses lives here under a name.

package secl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Two-wire bus addressing.

    // Fixed, hardwired device address of the EEPROM (1010 000b).
    localparam logic [6:0] EE_DEV_ADDR = 7'h50;
    // Direction bit appended to the device address.
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Image layout.

    // First word fetched; words are read in ascending order from here.
    localparam logic [7:0] FIRST_WORD = 8'h00;
    // Word that must hold the end-of-list marker, and the marker value.
    localparam logic [7:0] END_WORD = 8'h3a;
    localparam logic [7:0] END_MARK = 8'h80;
    // Single reserved words whose contents load nothing.
    localparam logic [7:0] RSV_WORD_A = 8'h0c;
    localparam logic [7:0] RSV_WORD_B = 8'h1b;
    localparam logic [7:0] RSV_WORD_C = 8'h1c;
    localparam logic [7:0] RSV_WORD_D = 8'h31;
    // Range of reserved words whose contents load nothing.
    localparam logic [7:0] RSV_RANGE_LO = 8'h35;
    localparam logic [7:0] RSV_RANGE_HI = 8'h38;
    // Link-enhancement word has reserved bits 5:3 and 0.
    localparam logic [7:0] LINK_ENH_WORD = 8'h27;
    localparam logic [7:0] LINK_ENH_MASK = 8'hc6;
    // Byte lane mask for an ordinary fully loaded word.
    localparam logic [7:0] FULL_MASK = 8'hff;

    ////////////////////////////////////////////////////////////////////////////
    // Serial-bus control and status byte.

    localparam int STAT_BUSY_BIT = 4;
    localparam int STAT_ERR_BIT = 0;
    localparam logic [7:0] STAT_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Link timing: a quarter of a bus bit period, at least 2500 ns.

    localparam int SCL_QUARTER_NS = 2500;
    localparam int LINK_PERIOD_NS = 160;
    localparam int QTR_CYC = (SCL_QUARTER_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam logic [4:0] QTR_LAST = 5'(QTR_CYC - 1);
    // Ninth bit slot of every byte carries the acknowledge.
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Types.

    // One destination register byte write.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic [7:0] mask;
    } secl_cfg_wr_type;

    // Which header byte the link is sending.
    typedef enum logic [1:0] {STEP_DEV_WR, STEP_WORD, STEP_DEV_RD} secl_step_type;

endpackage

// ==== logic/secl_loader.sv ====
// Purpose: Power-on loader that copies an EEPROM image into configuration bytes.
// Assumes: clk at 250 MHz; link_clk free running near 6.25 MHz; open-drain pins.
// Notes: The bus engine runs on link_clk and hands bytes to clk by toggles.
// Notes on behaviour
// - EEPROM is always addressed at 1010000b.
// - Byte 80h at word 3Ah ends loading.
// - Each word address names one destination byte.
// - Reserved words are read but change nothing.
// - Busy flag bit 4 high during download.
// - Error flag bit 0 reports download outcome.

`timescale 1ns/1ps

module secl_loader #(
    // Link cycles per quarter bit; a bench may shorten it to keep runs brief.
    parameter int QTR_CYCLES = secl_pkg::QTR_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic load_enable,
    input wire logic link_clk,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic cfg_wr,
    output secl_pkg::secl_cfg_wr_type cfg_wr_info,
    output logic [7:0] load_status
);
    import secl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Word decoding shared by the write path.

    // True for a word whose contents must not touch any register.
    function automatic logic word_is_reserved(input logic [7:0] w);
        word_is_reserved = (w == RSV_WORD_A) || (w == RSV_WORD_B) || (w == RSV_WORD_C)
            || (w == RSV_WORD_D) || ((w >= RSV_RANGE_LO) && (w <= RSV_RANGE_HI))
            || (w == END_WORD);
    endfunction

    // Bits of a word that really load; reserved bits are left alone.
    function automatic logic [7:0] word_mask(input logic [7:0] w);
        word_mask = (w == LINK_ENH_WORD) ? LINK_ENH_MASK : FULL_MASK;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Core domain declarations.

    typedef enum logic [1:0] {C_WAIT, C_RUN, C_END} secl_core_state_type;

    secl_core_state_type core_q; // Load sequencer in the core domain.
    logic alive_q;               // Low while the core is in reset; feeds link reset.
    logic en_s1, en_s2;          // Strap synchroniser for load_enable.
    logic go_q;                  // Level request to the link engine.
    logic busy_q;                // Load-in-progress flag.
    logic err_q;                 // Load-error flag.
    logic req_s1, req_s2;        // Byte-ready toggle from the link.
    logic ack_q;                 // Last toggle consumed; returned to the link.
    logic done_s1, done_s2;      // Link finished level.
    logic lerr_s1, lerr_s2;      // Link error level, stable before done rises.
    logic cfg_wr_q;              // One-cycle write strobe.
    secl_cfg_wr_type cfg_info_q; // Destination, data and mask of the strobe.

    ////////////////////////////////////////////////////////////////////////////
    // Link domain declarations.

    typedef enum logic [2:0] {L_IDLE, L_START, L_TX, L_RX, L_STOP, L_DONE} secl_link_state_type;

    secl_link_state_type lst_q;  // Bus engine state.
    logic lrst_s1, lrst_s2;      // Reset carried into the link domain.
    logic ce_s1, ce_s2;          // Clock enable carried into the link domain.
    logic go_s1, go_s2;          // Request from the core.
    logic ack_s1, ack_s2;        // Consumed toggle from the core.
    logic sda_s1, sda_s2;        // Data pin synchroniser.
    logic scl_s1, scl_s2;        // Clock pin synchroniser, for stretching.
    logic [4:0] div_q;           // Cycles within a quarter bit.
    logic [1:0] qtr_q;           // Quarter within a bit cell.
    logic [3:0] bit_q;           // Bit slot within a byte, 8 is acknowledge.
    logic [7:0] sh_q;            // Shift register for sent and received bits.
    secl_step_type step_q;       // Header byte being sent.
    logic rs_q;                  // Set once the repeated start is due.
    logic [7:0] word_q;          // Word address of the byte being read.
    logic [7:0] hold_addr_q;     // Byte handed to the core, stable until acked.
    logic [7:0] hold_data_q;
    logic req_q;                 // Byte-ready toggle.
    logic lerr_q;                // Link error level.
    logic done_q;                // Link finished level.
    logic sda_low_q, scl_low_q;  // Registered open-drain pulls.
    logic sda_low_d, scl_low_d;
    logic tick, stretch, stall, adv, lce;
    // Last cycle of a quarter; the divider is five bits, so at most 32 cycles.
    localparam logic [4:0] QTR_END = 5'(QTR_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Core: reset marker for the link domain.

    // A constant under reset; the link sees its low level through two flops.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alive_q <= 1'b0;
        end else begin
            alive_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core: synchronisers for the strap pin and the link levels.

    // The first stage of each pair is read only by the second.
    always_ff @(posedge clk) begin
        if (ce) begin
            en_s1 <= load_enable;
            en_s2 <= en_s1;
            req_s1 <= req_q;
            req_s2 <= req_s1;
            done_s1 <= done_q;
            done_s2 <= done_s1;
            lerr_s1 <= lerr_q;
            lerr_s2 <= lerr_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core: load sequencer and status flags.

    // The strap is sampled after reset release, never by the reset itself.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            core_q <= C_WAIT;
            go_q <= 1'b0;
            busy_q <= 1'b0;
            err_q <= 1'b0;
        end else if (ce) begin
            unique case (core_q)
                // Waiting for the EEPROM interface to be enabled.
                C_WAIT: begin
                    if (en_s2) begin
                        busy_q <= 1'b1;
                        err_q <= 1'b0;
                        go_q <= 1'b1;
                        core_q <= C_RUN;
                    end
                end
                // The link only raises done after the last byte was acked,
                // so the final write strobe has already gone out here.
                C_RUN: begin
                    if (done_s2) begin
                        busy_q <= 1'b0;
                        err_q <= lerr_s2;
                        go_q <= 1'b0;
                        core_q <= C_END;
                    end
                end
                // One load per reset; the flags keep their result.
                C_END: begin
                    core_q <= C_END;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core: byte write path.

    // The link holds its byte until ack_q matches, so the bundle is stable
    // whenever the synchronised toggle differs from the consumed one.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            cfg_wr_q <= 1'b0;
            cfg_info_q <= '0;
        end else if (ce) begin
            cfg_wr_q <= 1'b0;
            if (req_s2 != ack_q) begin
                ack_q <= req_s2;
                cfg_info_q <= '{addr: hold_addr_q, data: hold_data_q,
                                mask: word_mask(hold_addr_q)};
                cfg_wr_q <= !word_is_reserved(hold_addr_q);
            end
        end
    end

    // Status byte as software would see it; other bits read as zero.
    always_comb begin
        load_status = STAT_RESET;
        load_status[STAT_BUSY_BIT] = busy_q;
        load_status[STAT_ERR_BIT] = err_q;
    end

    assign cfg_wr = cfg_wr_q;
    assign cfg_wr_info = cfg_info_q;

    ////////////////////////////////////////////////////////////////////////////
    // Link: synchronisers.

    // Reset and enable cross like any other level.
    always_ff @(posedge link_clk) begin
        lrst_s1 <= alive_q;
        lrst_s2 <= lrst_s1;
        ce_s1 <= ce;
        ce_s2 <= ce_s1;
        go_s1 <= go_q;
        go_s2 <= go_s1;
        ack_s1 <= ack_q;
        ack_s2 <= ack_s1;
        sda_s1 <= sda_in;
        sda_s2 <= sda_s1;
        scl_s1 <= scl_in;
        scl_s2 <= scl_s1;
    end

    assign lce = ce_s2;

    ////////////////////////////////////////////////////////////////////////////
    // Link: bit timing.

    assign tick = (div_q == QTR_END);
    // A slave holding the clock low stretches the high phase.
    assign stretch = (qtr_q == 2'd1) && !scl_low_q && !scl_s2;
    // A new byte may not overwrite one the core has not taken yet.
    assign stall = (lst_q == L_RX) && (qtr_q == 2'd3) && (req_q != ack_s2)
        && ((bit_q == LAST_DATA_BIT) || ((bit_q == ACK_SLOT) && (word_q == END_WORD)));
    assign adv = tick && !stretch && !stall;

    // Quarter counter runs only while a transfer is under way.
    always_ff @(posedge link_clk) begin
        if (!lrst_s2) begin
            div_q <= '0;
            qtr_q <= '0;
        end else if (lce) begin
            if ((lst_q == L_IDLE) || (lst_q == L_DONE)) begin
                div_q <= '0;
                qtr_q <= '0;
            end else if (adv) begin
                div_q <= '0;
                qtr_q <= qtr_q + 2'd1;
            end else if (!tick) begin
                div_q <= div_q + 5'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link: transfer sequencer.

    // One random-read header, then a sequential read up to the marker word.
    always_ff @(posedge link_clk) begin
        if (!lrst_s2) begin
            lst_q <= L_IDLE;
            bit_q <= '0;
            sh_q <= '0;
            step_q <= STEP_DEV_WR;
            rs_q <= 1'b0;
            word_q <= FIRST_WORD;
            hold_addr_q <= '0;
            hold_data_q <= '0;
            req_q <= 1'b0;
            lerr_q <= 1'b0;
            done_q <= 1'b0;
        end else if (lce) begin
            unique case (lst_q)
                L_IDLE: begin
                    if (go_s2) begin
                        step_q <= STEP_DEV_WR;
                        rs_q <= 1'b0;
                        lerr_q <= 1'b0;
                        lst_q <= L_START;
                    end
                end
                L_START: begin
                    if (adv && (qtr_q == 2'd3)) begin
                        sh_q <= {EE_DEV_ADDR, rs_q ? DIR_READ : DIR_WRITE};
                        bit_q <= '0;
                        lst_q <= L_TX;
                    end
                end
                L_TX: begin
                    if (adv && (qtr_q == 2'd2) && (bit_q == ACK_SLOT) && sda_s2) begin
                        // A missing acknowledge aborts the load.
                        lerr_q <= 1'b1;
                    end
                    if (adv && (qtr_q == 2'd3)) begin
                        if (bit_q != ACK_SLOT) begin
                            bit_q <= bit_q + 4'd1;
                            sh_q <= {sh_q[6:0], 1'b0};
                        end else if (lerr_q) begin
                            lst_q <= L_STOP;
                        end else begin
                            bit_q <= '0;
                            unique case (step_q)
                                STEP_DEV_WR: begin
                                    sh_q <= FIRST_WORD;
                                    step_q <= STEP_WORD;
                                end
                                STEP_WORD: begin
                                    rs_q <= 1'b1;
                                    step_q <= STEP_DEV_RD;
                                    lst_q <= L_START;
                                end
                                STEP_DEV_RD: begin
                                    word_q <= FIRST_WORD;
                                    lst_q <= L_RX;
                                end
                            endcase
                        end
                    end
                end
                L_RX: begin
                    if (adv && (qtr_q == 2'd2) && (bit_q != ACK_SLOT)) begin
                        sh_q <= {sh_q[6:0], sda_s2};
                    end
                    if (adv && (qtr_q == 2'd3)) begin
                        if (bit_q == LAST_DATA_BIT) begin
                            hold_addr_q <= word_q;
                            hold_data_q <= sh_q;
                            req_q <= !req_q;
                            if ((word_q == END_WORD) && (sh_q != END_MARK)) begin
                                lerr_q <= 1'b1;
                            end
                            bit_q <= ACK_SLOT;
                        end else if (bit_q == ACK_SLOT) begin
                            if (word_q == END_WORD) begin
                                lst_q <= L_STOP;
                            end else begin
                                word_q <= word_q + 8'd1;
                                bit_q <= '0;
                            end
                        end else begin
                            bit_q <= bit_q + 4'd1;
                        end
                    end
                end
                L_STOP: begin
                    if (adv && (qtr_q == 2'd3)) begin
                        done_q <= 1'b1;
                        lst_q <= L_DONE;
                    end
                end
                // Four-phase return: done drops once the core drops go.
                L_DONE: begin
                    if (!go_s2) begin
                        done_q <= 1'b0;
                        lst_q <= L_IDLE;
                    end
                end
                default: begin
                    lst_q <= L_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link: pin drive.

    // Pulls per state and quarter; data bits change only while the clock is low.
    always_comb begin
        sda_low_d = 1'b0;
        scl_low_d = 1'b0;
        unique case (lst_q)
            L_START: begin
                sda_low_d = (qtr_q >= 2'd2);
                scl_low_d = (qtr_q == 2'd3) || ((qtr_q == 2'd0) && rs_q);
            end
            L_TX: begin
                scl_low_d = (qtr_q == 2'd0) || (qtr_q == 2'd3);
                sda_low_d = (bit_q != ACK_SLOT) && !sh_q[7];
            end
            L_RX: begin
                scl_low_d = (qtr_q == 2'd0) || (qtr_q == 2'd3);
                // Acknowledge every byte but the marker, which is refused.
                sda_low_d = (bit_q == ACK_SLOT) && (word_q != END_WORD);
            end
            L_STOP: begin
                scl_low_d = (qtr_q == 2'd0);
                sda_low_d = (qtr_q <= 2'd1);
            end
            default: begin
                sda_low_d = 1'b0;
                scl_low_d = 1'b0;
            end
        endcase
    end

    // Registered pulls keep decode glitches off the open-drain lines.
    always_ff @(posedge link_clk) begin
        if (!lrst_s2) begin
            sda_low_q <= 1'b0;
            scl_low_q <= 1'b0;
        end else if (lce) begin
            sda_low_q <= sda_low_d;
            scl_low_q <= scl_low_d;
        end
    end

    // Open drain: the pins only ever pull low.
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    assign sda_oe = sda_low_q;
    assign scl_oe = scl_low_q;

endmodule

// ==== sim/secl_loader_props.sv ====
// Purpose: Checker for the configuration write stream and status flags.
// Assumes: Core clock domain only; apart from the open-drain check on scl_out and sda_out, the link pins are left to the bench model.
// Notes: Bound to every loader instance.
`timescale 1ns/1ps
module secl_loader_props
    import secl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic load_enable,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic cfg_wr,
    input wire secl_pkg::secl_cfg_wr_type cfg_wr_info,
    input wire logic [7:0] load_status
);
    logic seen_q;
    logic [7:0] last_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Remember the previous write address so the order can be judged.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seen_q <= 1'b0;
            last_q <= 8'h00;
        end else if (cfg_wr) begin
            seen_q <= 1'b1;
            last_q <= cfg_wr_info.addr;
        end
    end
    // The marker byte arrives a whole byte later, so busy must outlast a write.
    sequence s_busy_hold;
        load_status[4] [*8];
    endsequence
    property p_wr_pulse; cfg_wr |=> !cfg_wr; endproperty
    property p_wr_busy; cfg_wr |-> load_status[4]; endproperty
    property p_rsv_skip;
        cfg_wr |-> !(cfg_wr_info.addr inside {8'h0c, 8'h1b, 8'h1c, 8'h31, [8'h35:8'h38]});
    endproperty
    property p_no_mark; cfg_wr |-> cfg_wr_info.addr < 8'h3a; endproperty
    property p_mask;
        cfg_wr |-> cfg_wr_info.mask == ((cfg_wr_info.addr == 8'h27) ? 8'hc6 : 8'hff);
    endproperty
    property p_asc; cfg_wr && seen_q |-> cfg_wr_info.addr > last_q; endproperty
    property p_busy_end; cfg_wr |=> s_busy_hold; endproperty
    property p_stat_zero; load_status[7:5] == 3'h0 && load_status[3:1] == 3'h0; endproperty
    property p_od_low; !scl_out && !sda_out; endproperty
    property p_err_keep;
        !load_status[4] && !$past(load_status[4]) |-> $stable(load_status[0]);
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");
    a_wr_busy: assert property (p_wr_busy) else $error("write seen while not loading");
    a_rsv_skip: assert property (p_rsv_skip) else $error("reserved word was written");
    a_no_mark: assert property (p_no_mark) else $error("write at or past the marker word");
    a_mask: assert property (p_mask) else $error("wrong byte lane mask");
    a_asc: assert property (p_asc) else $error("write addresses not ascending");
    a_busy_end: assert property (p_busy_end) else $error("busy dropped right after a write");
    a_stat_zero: assert property (p_stat_zero) else $error("unused status bits set");
    a_err_keep: assert property (p_err_keep) else $error("error flag moved after load");
    a_od_low: assert property (p_od_low) else $error("bus pin driven high");
endmodule
bind secl_loader secl_loader_props secl_loader_props_inst(.clk(clk), .rst_n(rst_n), .ce(ce),
    .load_enable(load_enable), .link_clk(link_clk), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .cfg_wr(cfg_wr),
    .cfg_wr_info(cfg_wr_info), .load_status(load_status));

// ==== sim/secl_eeprom_model.sv ====
// Purpose: Behavioural two-wire EEPROM slave holding a known image.
// Assumes: Pull-ups on both lines; the model only ever pulls SDA low.
// Notes: No clock stretching; data changes only while SCL is low.
`timescale 1ns/1ps
module secl_eeprom_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic nack_dev,
    input wire logic bad_mark,
    output logic sda_pull
);
    int bcnt = 0;
    int st = 3;
    logic [7:0] sh = 8'h00;
    logic [7:0] ptr = 8'h00;
    logic mnack = 1'b0;
    logic [7:0] ob = 8'h00;
    initial sda_pull = 1'b0;
    function automatic logic [7:0] img(logic [7:0] w);
        img = (w == 8'h3a) ? (bad_mark ? 8'h81 : 8'h80) : w + 8'h11;
    endfunction
    // START restarts framing, STOP idles the slave.
    always @(negedge sda) if (scl === 1'b1) begin
        bcnt = -1;
        st = 0;
        mnack = 1'b0;
    end
    always @(posedge sda) if (scl === 1'b1) st = 3;
    always @(posedge scl) begin
        if (bcnt < 8 && st != 2) sh = {sh[6:0], sda};
        if (bcnt == 8 && st == 2) mnack = sda;
    end
    // States: 0 device byte, 1 word byte, 2 sending, 3 idle.
    // A byte is judged as its acknowledge slot opens after the eighth bit, never at the
    // first clock fall after a START, when nothing has been shifted in yet.
    always @(negedge scl) begin
        if (bcnt == 8) begin
            bcnt = 0;
            sda_pull = 1'b0;
            if (st == 2 && mnack) st = 3;
            else if (st == 2) ptr = ptr + 8'h01;
            else if (st == 0) st = sh[0] ? 2 : 1;
        end else begin
            bcnt = bcnt + 1;
            if (bcnt == 8) begin
                if (st == 2) sda_pull = 1'b0;
                else if (st == 0 && sh[7:1] == 7'h50 && !nack_dev) sda_pull = 1'b1;
                else if (st == 0) st = 3;
                else if (st == 1) begin
                    ptr = sh;
                    sda_pull = 1'b1;
                end
            end
        end
        ob = img(ptr);
        if (st == 2 && bcnt < 8) sda_pull = !ob[7 - bcnt];
    end
endmodule

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench for the EEPROM configuration loader.
// Assumes: Open-drain lines with pull-ups; one full load takes about 1.5 ms.
// Notes: Reset is held long enough for the slow link domain to see it.
`timescale 1ns/1ps
module testbench;
    import secl_pkg::*;
    logic clk, link_clk, rst_n, ce, load_enable, nack_dev, bad_mark, pull, scl_w, sda_w;
    logic scl_out, scl_oe, sda_out, sda_oe, cfg_wr;
    secl_cfg_wr_type cfg_wr_info;
    logic [7:0] load_status, exp_w;
    int n_fail, compares, n_wr;
    assign scl_w = !scl_oe;
    assign sda_w = !(sda_oe | pull);
    secl_loader #(.QTR_CYCLES(4)) secl_loader_inst(.clk(clk), .rst_n(rst_n), .ce(ce),
        .load_enable(load_enable), .link_clk(link_clk), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .cfg_wr(cfg_wr),
        .cfg_wr_info(cfg_wr_info), .load_status(load_status));
    secl_eeprom_model secl_eeprom_model_inst(.scl(scl_w), .sda(sda_w), .nack_dev(nack_dev),
        .bad_mark(bad_mark), .sda_pull(pull));
    initial begin clk = 1'b0; forever #2 clk = ~clk; end
    initial begin link_clk = 1'b0; #37; forever #80 link_clk = ~link_clk; end
    function automatic logic rsv(logic [7:0] w);
        rsv = w inside {8'h0c, 8'h1b, 8'h1c, 8'h31, [8'h35:8'h38]};
    endfunction
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Each write must be the next loadable word with its image byte.
    always @(negedge clk) if (cfg_wr === 1'b1) begin
        while (rsv(exp_w)) exp_w++;
        check("wr addr", exp_w, cfg_wr_info.addr);
        check("wr data", exp_w + 8'h11, cfg_wr_info.data);
        check("wr mask", (exp_w == 8'h27) ? 8'hc6 : 8'hff, cfg_wr_info.mask);
        exp_w++;
        n_wr++;
    end
    // Long reset: the link domain needs three of its own periods to see it.
    task automatic start_load(logic nk, logic bd, logic en);
        @(negedge clk);
        rst_n = 1'b0;
        load_enable = 1'b0;
        nack_dev = nk;
        bad_mark = bd;
        repeat (130) @(negedge clk);
        rst_n = 1'b1;
        exp_w = 8'h00;
        n_wr = 0;
        check("status in reset", 8'h00, load_status);
        load_enable = en;
    endtask
    task automatic run_load(string name, logic nk, logic bd, int exp_n);
        int i;
        start_load(nk, bd, 1'b1);
        repeat (4) @(negedge clk);
        check("busy set", 8'h10, load_status);
        i = 0;
        while (load_status[4] !== 1'b0 && i < 450000) begin
            @(negedge clk);
            i++;
        end
        check("end status", {7'h00, nk | bd}, load_status);
        repeat (2000) @(negedge clk);
        check("write count", 8'(exp_n), 8'(n_wr));
        $display("test %s done", name);
    endtask
    task automatic t_idle();
        start_load(1'b0, 1'b0, 1'b0);
        repeat (2000) @(negedge clk);
        check("idle status", 8'h00, load_status);
        check("idle writes", 8'h00, 8'(n_wr));
        $display("test idle done");
    endtask
    task automatic t_good(); run_load("good", 1'b0, 1'b0, 50); endtask
    task automatic t_bad_mark(); run_load("bad_mark", 1'b0, 1'b1, 50); endtask
    task automatic t_nack(); run_load("nack", 1'b1, 1'b0, 0); endtask
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        load_enable = 1'b0;
        nack_dev = 1'b0;
        bad_mark = 1'b0;
        n_fail = 0;
        compares = 0;
        n_wr = 0;
        exp_w = 8'h00;
        t_idle();
        t_good();
        t_nack();
        t_bad_mark();
        stop_test();
    end
    initial begin
        #4500000;
        n_fail++;
        stop_test();
    end
endmodule
